//--- inc/buck_fault_pkg.sv
// Purpose: shared constants and types of the buck fault supervisor
// Assumes: mclk at 100 MHz, comparators deliver digital levels
// Notes: register map sits on an AHB-Lite slave, one word per register
// Notes on behaviour
// - under-voltage armed only after regulation delay
// - feedback low over 1 us: both switches off
// - latch-off leaves only on enable/supply toggle or on thermal cutoff
// - over-voltage armed from soft start to shutdown
// - over-voltage over 1 us: flag low, high-side off
// - after over-voltage, reference ramps down at soft-start slope
// - low-side toggles with hysteresis during ramp-down
// - reference at zero: high-side off, low-side on
// - threshold fixed 2.0 V, then reference plus 200 mV
// - high-side held off while current above valley limit
// - over-current armed from soft start to shutdown
// - over-current over 50 us latches converter off
// - thermal cutoff only while supply and enable valid
// - hot: shut down; cooled: normal power-up
package buck_fault_pkg;
  // clock rate and filter times
  localparam int CLK_MHZ = 100;
  localparam int FILT_NS = 1000;
  localparam int FILT_CYC = (FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int OC_US = 50;
  localparam int OC_CYC = OC_US * CLK_MHZ;
  // defaults for timing not fixed by the converter itself
  localparam int PG_DELAY_CYC_DEF = 1000;
  localparam int SS_STEP_CYC_DEF = 10;
  // reference and threshold values in mV
  localparam int DAC_W = 12;
  localparam logic [11:0] OV_FIXED_MV = 12'h7D0;
  localparam logic [11:0] OV_OFFSET_MV = 12'h0C8;
  localparam logic [11:0] TARGET_RST = 12'h4B0;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  // status field positions
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_REG_BIT = 3;
  localparam int STAT_DAC_LSB = 16;
  // interrupt bits
  localparam int IRQ_UV = 0;
  localparam int IRQ_OV = 1;
  localparam int IRQ_OC = 2;
  localparam int IRQ_TH = 3;
  localparam int IRQ_W = 4;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;
  // supervisor states
  typedef enum logic [2:0] {
    ST_OFF, ST_SOFT, ST_PGDLY, ST_RUN, ST_OVRAMP, ST_OVHOLD, ST_LATCH, ST_THERM
  } supState_t;
endpackage

//--- design/duration_filter.sv
// Purpose: flags a level that has stood longer than a cycle limit
// Assumes: level is already synchronous to mclk
// Notes: count restarts whenever the level drops
`timescale 1ns/10ps
module duration_filter #(
  parameter int CNT_W = 16
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic level,
  input wire logic [CNT_W-1:0] limit,
  output logic tripped
);
  logic [CNT_W-1:0] cnt_q; // cycles the level has stood

  // saturating run-length counter
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      cnt_q <= '0;
    else if (clkEn)
    begin
      if (!level)
        cnt_q <= '0;
      else if (cnt_q != limit)
        cnt_q <= cnt_q + 1'b1;
    end
  end

  // trips one cycle past the limit, so strictly longer than it
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      tripped <= 1'b0;
    else if (clkEn)
      tripped <= level && (cnt_q == limit);
  end

  chk_filter_drop: assert property (@(posedge mclk) disable iff (reset || !clkEn)
    !level |=> !tripped) else $error("filter tripped without level");
endmodule

//--- design/buck_fault_supervisor.sv
// Purpose: protection sequencer of a single-phase buck regulator
// Assumes: comparator and supply levels arrive asynchronously
// Notes: gate outputs permit or force switches; PWM lives elsewhere
//
// Added by the designer: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module buck_fault_supervisor
  import buck_fault_pkg::*;
#(
  parameter int PG_DELAY_CYC = PG_DELAY_CYC_DEF,
  parameter int SS_STEP_CYC = SS_STEP_CYC_DEF,
  parameter int OC_PERSIST_CYC = OC_CYC
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic enablePin,
  input wire logic supplyValid,
  input wire logic fbUnderLevel,
  input wire logic fbOverThreshold,
  input wire logic fbBelowHyst,
  input wire logic currentOverValley,
  input wire logic dieOverTrip,
  input wire logic dieUnderRecover,
  output logic outputInRegulation,
  output logic hsGateEn,
  output logic lsGateEn,
  output logic lsForceOn,
  output logic [DAC_W-1:0] dacCode,
  output logic [DAC_W-1:0] ovThreshold,
  output logic ovThreshSel,
  output logic irq
);
  localparam int NIN = 8;
  localparam logic [15:0] FILT_LIM = 16'(FILT_CYC);
  localparam logic [15:0] OC_LIM = 16'(OC_PERSIST_CYC);
  localparam logic [15:0] PG_LAST = 16'(PG_DELAY_CYC - 1);
  localparam logic [15:0] SS_LAST = 16'(SS_STEP_CYC - 1);

  logic [NIN-1:0] pinRaw; // raw asynchronous levels
  logic [NIN-1:0] meta_q; // first synchroniser stage
  logic [NIN-1:0] sync_q; // second stage, safe to read
  logic enOk, supOk, powerOk; // enable and supply valid
  logic uvLow, ovHigh, hystLow, overValley, hot, cool;
  supState_t state_q, stateD; // supervisor state
  logic [2:0] filtIn; // armed comparator levels
  logic [2:0] trip; // filtered trips: uv, ov, oc
  logic [15:0] stepCnt_q; // slope prescaler
  logic stepTick; // one reference step due
  logic [15:0] pgCnt_q; // regulation delay timer
  logic pgDone; // delay expired
  logic [DAC_W-1:0] target_q; // programmed output level
  logic [IRQ_W-1:0] irqStat_q, irqMask_q, irqEvt, irqClr;
  logic wrPend_q; // write data phase pending
  logic [7:0] wrAddr_q; // address of that write
  logic addrPhase; // valid address phase on bus
  logic [31:0] rdMux; // read data for the current address

  assign pinRaw = {dieUnderRecover, dieOverTrip, currentOverValley, fbBelowHyst,
                   fbOverThreshold, fbUnderLevel, supplyValid, enablePin};

  // two-stage synchroniser for every pin level
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else if (clkEn)
    begin
      meta_q <= pinRaw;
      sync_q <= meta_q;
    end
  end

  assign enOk = sync_q[0];
  assign supOk = sync_q[1];
  assign uvLow = sync_q[2];
  assign ovHigh = sync_q[3];
  assign hystLow = sync_q[4];
  assign overValley = sync_q[5];
  assign hot = sync_q[6];
  assign cool = sync_q[7];
  assign powerOk = enOk && supOk;

  // detection windows around soft start and shutdown
  assign filtIn[0] = uvLow && (state_q == ST_RUN);
  assign filtIn[1] = ovHigh && (state_q == ST_SOFT || state_q == ST_PGDLY || state_q == ST_RUN);
  assign filtIn[2] = overValley && (state_q == ST_SOFT || state_q == ST_PGDLY || state_q == ST_RUN);

  // one persistence filter each for uv, ov and oc; over-current waits far longer
  for (genvar i = 0; i < 3; i++)
  begin : g_filt
    duration_filter #(.CNT_W(16)) u_filt (
      .mclk(mclk),
      .reset(reset),
      .clkEn(clkEn),
      .level(filtIn[i]),
      .limit(i == 2 ? OC_LIM : FILT_LIM),
      .tripped(trip[i])
    );
  end

  // slope prescaler shared by ramp-up and ramp-down, so slopes match
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      stepCnt_q <= '0;
    else if (clkEn)
      stepCnt_q <= stepTick ? '0 : stepCnt_q + 1'b1;
  end
  assign stepTick = (stepCnt_q == SS_LAST);

  // regulation delay after soft start
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      pgCnt_q <= '0;
    else if (clkEn)
      pgCnt_q <= (state_q == ST_PGDLY && !pgDone) ? pgCnt_q + 1'b1 : '0;
  end
  assign pgDone = (pgCnt_q == PG_LAST);

  // next state: loss of enable or supply beats everything
  always_comb
  begin
    stateD = state_q;
    if (!powerOk)
      stateD = ST_OFF;
    else if (hot && state_q != ST_THERM)
      stateD = ST_THERM;
    else
    begin
      unique case (state_q)
        ST_OFF:
          stateD = ST_SOFT;
        ST_SOFT, ST_PGDLY, ST_RUN:
        begin
          if (trip[1])
            stateD = ST_OVRAMP;
          else if (trip[0] || trip[2])
            stateD = ST_LATCH;
          else if (state_q == ST_SOFT && dacCode >= target_q)
            stateD = ST_PGDLY;
          else if (state_q == ST_PGDLY && pgDone)
            stateD = ST_RUN;
        end
        ST_OVRAMP:
          if (dacCode == '0)
            stateD = ST_OVHOLD;
        ST_OVHOLD, ST_LATCH:
          stateD = state_q;
        ST_THERM:
          if (cool)
            stateD = ST_OFF;
      endcase
    end
  end

  // state register
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      state_q <= ST_OFF;
    else if (clkEn)
      state_q <= stateD;
  end

  // reference DAC: up in soft start, down after over-voltage
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      dacCode <= '0;
    else if (clkEn)
    begin
      if (state_q == ST_SOFT)
      begin
        if (stepTick && dacCode < target_q)
          dacCode <= dacCode + 1'b1;
      end
      else if (state_q == ST_OVRAMP)
      begin
        if (stepTick && dacCode != '0)
          dacCode <= dacCode - 1'b1;
      end
      else if (state_q != ST_PGDLY && state_q != ST_RUN)
        dacCode <= '0; // discharged when off, latched or hot
    end
  end

  // over-voltage threshold selection for the comparator
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      ovThreshSel <= 1'b0;
      ovThreshold <= OV_FIXED_MV;
    end
    else if (clkEn)
    begin
      if (state_q == ST_OVRAMP || state_q == ST_OVHOLD)
      begin
        ovThreshSel <= 1'b1;
        ovThreshold <= DAC_W'(dacCode + OV_OFFSET_MV);
      end
      else
      begin
        ovThreshSel <= 1'b0;
        ovThreshold <= OV_FIXED_MV;
      end
    end
  end

  // gate permissions and regulation flag
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      hsGateEn <= 1'b0;
      lsGateEn <= 1'b0;
      lsForceOn <= 1'b0;
      outputInRegulation <= 1'b0;
    end
    else if (clkEn)
    begin
      outputInRegulation <= (state_q == ST_RUN);
      if (state_q == ST_SOFT || state_q == ST_PGDLY || state_q == ST_RUN)
      begin
        // skip the high-side pulse while current sits above the valley limit
        hsGateEn <= !overValley;
        lsGateEn <= 1'b1;
        lsForceOn <= 1'b0;
      end
      else if (state_q == ST_OVRAMP)
      begin
        hsGateEn <= 1'b0;
        lsGateEn <= 1'b1;
        // hysteresis band keeps the low side from chattering
        if (ovHigh)
          lsForceOn <= 1'b1;
        else if (hystLow)
          lsForceOn <= 1'b0;
      end
      else if (state_q == ST_OVHOLD)
      begin
        hsGateEn <= 1'b0;
        lsGateEn <= 1'b1;
        lsForceOn <= 1'b1;
      end
      else
      begin
        // off, latched or hot: both switches off
        hsGateEn <= 1'b0;
        lsGateEn <= 1'b0;
        lsForceOn <= 1'b0;
      end
    end
  end

  // fault events feeding the interrupt status
  always_comb
  begin
    irqEvt = '0;
    irqEvt[IRQ_UV] = (stateD == ST_LATCH) && (state_q != ST_LATCH) && trip[0];
    irqEvt[IRQ_OC] = (stateD == ST_LATCH) && (state_q != ST_LATCH) && trip[2];
    irqEvt[IRQ_OV] = (stateD == ST_OVRAMP) && (state_q != ST_OVRAMP);
    irqEvt[IRQ_TH] = (stateD == ST_THERM) && (state_q != ST_THERM);
  end

  // bus address phase is taken only when the bus is ready
  assign addrPhase = hsel && htrans[1] && hready;
  assign irqClr = (wrPend_q && wrAddr_q == ADDR_IRQ_STAT) ? hwdata[IRQ_W-1:0] : '0;

  // sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      irqStat_q <= '0;
    else if (clkEn)
      irqStat_q <= (irqStat_q & ~irqClr) | irqEvt;
  end

  // level interrupt from unmasked status
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      irq <= 1'b0;
    else if (clkEn)
      irq <= |(irqStat_q & irqMask_q);
  end

  // address phase capture for writes
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      wrPend_q <= 1'b0;
      wrAddr_q <= '0;
    end
    else if (clkEn)
    begin
      wrPend_q <= addrPhase && hwrite;
      if (addrPhase)
        wrAddr_q <= haddr[7:0];
    end
  end

  // writable registers, updated in the data phase
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      target_q <= TARGET_RST;
      irqMask_q <= IRQ_MASK_RST;
    end
    else if (clkEn && wrPend_q)
    begin
      if (wrAddr_q == ADDR_CTRL)
        target_q <= hwdata[DAC_W-1:0];
      else if (wrAddr_q == ADDR_IRQ_MASK)
        irqMask_q <= hwdata[IRQ_W-1:0];
    end
  end

  // read multiplexer; unmapped addresses read zero
  always_comb
  begin
    rdMux = '0;
    unique case (haddr[7:0])
      ADDR_CTRL:
        rdMux[DAC_W-1:0] = target_q;
      ADDR_STATUS:
      begin
        rdMux[STAT_STATE_LSB +: 3] = state_q;
        rdMux[STAT_REG_BIT] = outputInRegulation;
        rdMux[STAT_DAC_LSB +: DAC_W] = dacCode;
      end
      ADDR_IRQ_STAT:
        rdMux[IRQ_W-1:0] = irqStat_q;
      ADDR_IRQ_MASK:
        rdMux[IRQ_W-1:0] = irqMask_q;
      default:
        rdMux = '0;
    endcase
  end

  // zero wait states: read data registered at the address phase
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else if (clkEn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= (addrPhase && !hwrite) ? rdMux : '0;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset || !clkEn);

  sequence sAllOff;
    !outputInRegulation && !hsGateEn && !lsGateEn && !lsForceOn;
  endsequence
  sequence sLatchedOff;
    state_q == ST_LATCH ##1 sAllOff;
  endsequence

  chk_uv_window: assert property (state_q != ST_RUN |=> !trip[0])
    else $error("under-voltage armed outside run");
  chk_uv_latch: assert property ($rose(trip[0]) && !trip[1] && state_q == ST_RUN && powerOk && !hot
    |=> sLatchedOff) else $error("under-voltage did not latch off");
  chk_latch_hold: assert property (state_q == ST_LATCH && powerOk && !hot |=> state_q == ST_LATCH)
    else $error("latch left without toggle");
  chk_ov_window: assert property (!(state_q inside {ST_SOFT, ST_PGDLY, ST_RUN}) |=> !trip[1])
    else $error("over-voltage armed outside window");
  chk_ov_trip: assert property (state_q == ST_OVRAMP |=> !hsGateEn && !outputInRegulation && lsGateEn)
    else $error("over-voltage trip outputs wrong");
  chk_ov_ramp: assert property (state_q == ST_OVRAMP && stepTick && dacCode != '0
    |=> dacCode == $past(dacCode) - 1'b1) else $error("ramp-down step wrong");
  chk_ls_follow: assert property (state_q == ST_OVRAMP && ovHigh |=> lsForceOn)
    else $error("low side not on above threshold");
  chk_ov_hold: assert property (state_q == ST_OVHOLD |=> !hsGateEn && lsForceOn ##1 state_q != ST_OVHOLD || lsForceOn)
    else $error("hold state outputs wrong");
  chk_ov_thresh: assert property (ovThreshSel |-> ovThreshold == DAC_W'($past(dacCode) + OV_OFFSET_MV))
    else $error("ramp threshold wrong");
  chk_ov_fixed: assert property (!ovThreshSel |-> ovThreshold == OV_FIXED_MV)
    else $error("fixed threshold wrong");
  chk_valley: assert property (overValley && state_q == ST_RUN |=> !hsGateEn)
    else $error("high side allowed above valley limit");
  chk_oc_window: assert property (!(state_q inside {ST_SOFT, ST_PGDLY, ST_RUN}) |=> !trip[2])
    else $error("over-current armed outside window");
  chk_oc_latch: assert property ($rose(trip[2]) && !trip[1] && powerOk && !hot
    |=> sLatchedOff) else $error("over-current did not latch off");
  chk_therm_gate: assert property (!powerOk |=> state_q == ST_OFF)
    else $error("not off without enable or supply");
  chk_therm_off: assert property (hot && powerOk |=> state_q == ST_THERM ##1 sAllOff)
    else $error("thermal cutoff missing");
endmodule

//--- tb/fb_plant_model.sv
// Purpose: behavioural feedback node and its comparators beside the supervisor
// Assumes: feedback tracks the reference a cycle late unless the bench forces a level
// Notes: hysteresis band is a plain parameter, not a converter figure
`timescale 1ns/10ps
module fb_plant_model
  import buck_fault_pkg::*;
#(
  parameter int HYST_MV = 50
) (
  input wire logic mclk,
  input wire logic [DAC_W-1:0] dacCode,
  input wire logic [DAC_W-1:0] ovThreshold,
  input wire logic forceEn,
  input wire logic [DAC_W-1:0] forceMv,
  output logic fbUnderLevel,
  output logic fbOverThreshold,
  output logic fbBelowHyst
);
  logic [DAC_W-1:0] fbMv_q; // present feedback level in mV
  // output node lags the reference by one clock, as a slow plant would
  always_ff @(posedge mclk)
  begin
    fbMv_q <= forceEn ? forceMv : dacCode;
  end
  // comparators; under-level point is a fixed 200 mV
  assign fbUnderLevel = fbMv_q < 12'h0C8;
  assign fbOverThreshold = fbMv_q > ovThreshold;
  // band below threshold lets the low-side release
  assign fbBelowHyst = int'(fbMv_q) < int'(ovThreshold) - HYST_MV;
endmodule

//--- tb/buck_fault_supervisor_tb.sv
// Purpose: self-checking bench of the buck fault supervisor
// Assumes: short soft-start, delay and over-current persistence counts set through parameters
// Notes: state is polled through the status register; gates sampled at falling edges
`timescale 1ns/10ps
module buck_fault_supervisor_tb;
  import buck_fault_pkg::*;
  logic mclk, reset, hsel, hwrite, hreadyout, hresp, irq; // clock, reset and bus
  logic [31:0] haddr, hwdata, hrdata; // bus address and data
  logic [1:0] htrans; // transfer kind
  logic enablePin, supplyValid, currentOverValley, dieOverTrip, dieUnderRecover; // pins
  logic fbUnderLevel, fbOverThreshold, fbBelowHyst; // plant comparators
  logic outputInRegulation, hsGateEn, lsGateEn, lsForceOn, ovThreshSel; // gate side
  logic [DAC_W-1:0] dacCode, ovThreshold, forceMv; // reference and threshold
  logic forceEn; // bench overrides the feedback level
  logic clkEn; // clock enable of the supervisor
  int errorCnt, testsRun; // mismatch and comparison counts
  buck_fault_supervisor #(.PG_DELAY_CYC(20), .SS_STEP_CYC(2), .OC_PERSIST_CYC(50)) dut (.mclk(mclk),
    .reset(reset), .clkEn(clkEn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .enablePin(enablePin), .supplyValid(supplyValid), .fbUnderLevel(fbUnderLevel),
    .fbOverThreshold(fbOverThreshold), .fbBelowHyst(fbBelowHyst), .currentOverValley(currentOverValley),
    .dieOverTrip(dieOverTrip), .dieUnderRecover(dieUnderRecover), .outputInRegulation(outputInRegulation),
    .hsGateEn(hsGateEn), .lsGateEn(lsGateEn), .lsForceOn(lsForceOn), .dacCode(dacCode),
    .ovThreshold(ovThreshold), .ovThreshSel(ovThreshSel), .irq(irq));
  fb_plant_model plant (.mclk(mclk), .dacCode(dacCode), .ovThreshold(ovThreshold), .forceEn(forceEn),
    .forceMv(forceMv), .fbUnderLevel(fbUnderLevel), .fbOverThreshold(fbOverThreshold),
    .fbBelowHyst(fbBelowHyst));
  // 100 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // verdict and end of run
  task automatic results();
    $display("comparisons %0d mismatches %0d", testsRun, errorCnt);
    if (errorCnt == 0 && testsRun > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one comparison; unknowns never match
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // single transfer: address phase, then data phase; entered just after a rising edge
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    // address phase stands until ready is seen at a rising edge
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    // select dropped here, so a following call never reassigns it in one step
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    // data phase: read data taken at the edge that sees ready
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    chk("bus response", {31'h0, hresp}, 32'h0);
    if (n >= 100)
    begin
      chk("bus answer", 32'h0, 32'h1);
      results();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask
  task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0, r);
    chk(nm, r & m, e);
  endtask
  // poll the state field under a bound
  task automatic waitState(input supState_t s, input int lim);
    logic [31:0] d;
    int n;
    n = 0;
    do
    begin
      bus(ADDR_STATUS, 1'b0, 32'h0, d);
      n++;
    end
    while (d[2:0] !== s && n < lim);
    chk("state", {29'h0, d[2:0]}, {29'h0, s});
    if (d[2:0] !== s)
      results();
  endtask
  // regulation flag, high-side, low-side permit, low-side force
  task automatic gates(input logic [3:0] e);
    @(negedge mclk);
    chk("gates", {28'h0, outputInRegulation, hsGateEn, lsGateEn, lsForceOn}, {28'h0, e});
    @(posedge mclk);
  endtask
  // enable toggle restarts from a latched state
  task automatic toggleEn();
    enablePin <= 1'b0;
    waitState(ST_OFF, 20);
    enablePin <= 1'b1;
    waitState(ST_RUN, 400);
  endtask
  // hang guard
  initial
  begin
    cyc(90000);
    chk("run length", 32'h0, 32'h1);
    results();
  end
  // main sequence
  initial
  begin
    errorCnt = 0;
    testsRun = 0;
    {hsel, hwrite, htrans, haddr, hwdata, forceEn, forceMv} = '0;
    {enablePin, supplyValid, currentOverValley, dieOverTrip} = '0;
    dieUnderRecover = 1'b1;
    clkEn = 1'b1;
    reset = 1'b1;
    cyc(8);
    reset <= 1'b0;
    cyc(1);
    // reset values, unmapped place, target write
    rdChk("target", ADDR_CTRL, 32'hFFFFFFFF, {20'h0, TARGET_RST});
    rdChk("mask", ADDR_IRQ_MASK, 32'hFFFFFFFF, 32'h0);
    rdChk("events", ADDR_IRQ_STAT, 32'hFFFFFFFF, 32'h0);
    rdChk("unmapped", 8'h40, 32'hFFFFFFFF, 32'h0);
    chk("threshold", {20'h0, ovThreshold}, {20'h0, OV_FIXED_MV});
    wr(ADDR_CTRL, 32'h00000100);
    rdChk("target", ADDR_CTRL, 32'hFFFFFFFF, 32'h00000100);
    // power-up: feedback sits under 0.2 V for most of soft start
    enablePin <= 1'b1;
    supplyValid <= 1'b1;
    waitState(ST_RUN, 600);
    gates(4'hE);
    rdChk("status dac", ADDR_STATUS, 32'h0FFF0000, 32'h01000000);
    // short dip is filtered; valley limit skips the high-side
    forceMv <= 12'h064;
    forceEn <= 1'b1;
    cyc(50);
    forceEn <= 1'b0;
    currentOverValley <= 1'b1;
    cyc(20);
    gates(4'hA);
    currentOverValley <= 1'b0;
    cyc(5);
    waitState(ST_RUN, 1);
    // frozen by clock enable: a long dip must not be counted
    forceEn <= 1'b1;
    clkEn <= 1'b0;
    cyc(200);
    forceEn <= 1'b0;
    cyc(2);
    clkEn <= 1'b1;
    waitState(ST_RUN, 1);
    gates(4'hE);
    // under-voltage latch with interrupt masked
    forceEn <= 1'b1;
    waitState(ST_LATCH, 200);
    gates(4'h0);
    forceEn <= 1'b0;
    cyc(200);
    waitState(ST_LATCH, 1);
    rdChk("uv event", ADDR_IRQ_STAT, 32'hFFFFFFFF, 32'h1);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(ADDR_IRQ_MASK, 32'hF);
    cyc(3);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(ADDR_IRQ_STAT, 32'h1);
    rdChk("uv cleared", ADDR_IRQ_STAT, 32'hFFFFFFFF, 32'h0);
    cyc(3);
    chk("irq clear", {31'h0, irq}, 32'h0);
    toggleEn();
    // over-current persists past its limit, supply toggle restarts
    currentOverValley <= 1'b1;
    waitState(ST_LATCH, 200);
    rdChk("oc event", ADDR_IRQ_STAT, 32'hFFFFFFFF, 32'h4);
    wr(ADDR_IRQ_STAT, 32'h4);
    currentOverValley <= 1'b0;
    supplyValid <= 1'b0;
    waitState(ST_OFF, 20);
    supplyValid <= 1'b1;
    waitState(ST_RUN, 400);
    // over-voltage trip, ramp-down and hold
    forceMv <= 12'h834;
    forceEn <= 1'b1;
    waitState(ST_OVRAMP, 200);
    gates(4'h3);
    chk("thresh sel", {31'h0, ovThreshSel}, 32'h1);
    forceMv <= 12'h000;
    cyc(5);
    gates(4'h2);
    @(negedge mclk);
    forceMv <= dacCode;
    cyc(20);
    @(negedge mclk);
    chk("ramp slope", {20'h0, forceMv - dacCode}, 32'hA);
    waitState(ST_OVHOLD, 400);
    gates(4'h3);
    chk("hold threshold", {20'h0, ovThreshold}, {20'h0, OV_OFFSET_MV});
    rdChk("ov event", ADDR_IRQ_STAT, 32'hFFFFFFFF, 32'h2);
    wr(ADDR_IRQ_STAT, 32'h2);
    forceEn <= 1'b0;
    toggleEn();
    chk("thresh sel", {31'h0, ovThreshSel}, 32'h0);
    // thermal cut-off and automatic recovery
    dieOverTrip <= 1'b1;
    dieUnderRecover <= 1'b0;
    waitState(ST_THERM, 20);
    gates(4'h0);
    dieOverTrip <= 1'b0;
    cyc(20);
    waitState(ST_THERM, 1);
    dieUnderRecover <= 1'b1;
    waitState(ST_RUN, 600);
    rdChk("hot event", ADDR_IRQ_STAT, 32'hFFFFFFFF, 32'h8);
    wr(ADDR_IRQ_STAT, 32'h8);
    // no thermal detection while disabled
    enablePin <= 1'b0;
    waitState(ST_OFF, 20);
    dieOverTrip <= 1'b1;
    dieUnderRecover <= 1'b0;
    cyc(20);
    waitState(ST_OFF, 1);
    rdChk("no hot event", ADDR_IRQ_STAT, 32'hFFFFFFFF, 32'h0);
    results();
  end
endmodule
